/* hdl/mpsu_pkg.sv */
`default_nettype none
package mpsu_pkg;
    localparam logic [3:0] PRS_OFF   = 4'h0;
    localparam logic [3:0] PRS_10BT  = 4'h1;
    localparam logic [3:0] PRS_USB   = 4'h2;
    localparam logic [3:0] PRS_UART  = 4'h3;
    localparam logic [3:0] PRS_SPI   = 4'h5;
    localparam logic [3:0] PRS_GENERAL_SERIAL_MODE  = 4'h6;
    localparam logic [7:0] SYNC_USB  = 8'h01;
    localparam logic [7:0] SYNC_SFD  = 8'hab;
    localparam int CLK_PERIOD_PS     = 4000;
    localparam int PREEMPH_DELAY_PS  = 50000;
    localparam int PREEMPH_CYC       = (PREEMPH_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] OVS_LAST  = 4'hf;
    localparam logic [3:0] WAIT_LAST = 4'h7;
    localparam logic [2:0] STUFF_RUN = 3'h6;

    typedef struct packed {
        logic [3:0] protocol_sel;
        logic       rx_invert;
        logic       tx_invert;
        logic       ext_clk;
        logic       rx_full_irq_en;
        logic       tx_empty_irq_en;
        logic       tx_underrun_irq_en;
    } mpsu_cfg_s;

    typedef enum logic [2:0] {
        RX_HUNT  = 3'b001,
        RX_START = 3'b010,
        RX_DATA  = 3'b100
    } mpsu_rx_e;
endpackage : mpsu_pkg
`default_nettype wire

/* hdl/mpsu_top.sv */
`default_nettype none
module mpsu_top #(
    parameter int DW        = 8,
    parameter int CW        = 4,
    parameter int INT_DIV   = 4,
    parameter int EOP_SLOTS = 2
) (
    input  wire logic               CLK_I,
    input  wire logic               RST_I,
    input  wire mpsu_pkg::mpsu_cfg_s CFG_I,
    input  wire logic [7:0]         SYNC_PATTERN_REG_I,
    input  wire logic [CW-1:0]      RX_BIT_COUNT_REG_I,
    output logic [DW-1:0]           RX_BUFFER_REG_O,
    output logic [CW-1:0]           RX_COUNT_O,
    output logic                    RX_LOAD_O,
    output logic                    RX_EOP_O,
    input  wire logic               RX_EOP_CLR_I,
    input  wire logic [DW-1:0]      TX_BUFFER_REG_I,
    input  wire logic [CW-1:0]      TX_COUNT_I,
    input  wire logic               TX_LOAD_I,
    output logic                    TX_READY_O,
    output logic                    IRQ_O,
    input  wire logic               SERIAL_CLK_PIN_I,
    input  wire logic               RX_SERIAL_IN_I,
    input  wire logic               RX_PLUS_I,
    input  wire logic               RX_MINUS_I,
    output logic                    TX_PLUS_O,
    output logic                    TX_MINUS_O,
    output logic                    TX_PLUS_PREEMPH_O,
    output logic                    TX_MINUS_PREEMPH_O,
    output logic                    XCVR_OUT_EN_N_O
);
    localparam int PD = mpsu_pkg::PREEMPH_CYC - 1;

    // Reserved protocol codes match none of these and idle the lines as disabled, but unlike PRS_OFF do not end RX_DATA or clear tact
    function automatic logic f_diff(input logic [3:0] m);
        return m == mpsu_pkg::PRS_10BT || m == mpsu_pkg::PRS_USB;
    endfunction : f_diff

    function automatic logic f_plain(input logic [3:0] m);
        return m == mpsu_pkg::PRS_UART || m == mpsu_pkg::PRS_SPI || m == mpsu_pkg::PRS_GENERAL_SERIAL_MODE;
    endfunction : f_plain

    logic [3:0]         mode;
    logic [3:0]         s1;
    logic [3:0]         s2;
    logic               clk_d;
    logic [15:0]        div;
    logic               src_tick;
    logic               inv_bit;
    mpsu_pkg::mpsu_rx_e rx_state;
    logic [3:0]         rx_div;
    logic               nrzi_prev;
    logic               man_half;
    logic [2:0]         ones;
    logic [7:0]         hist;
    logic [DW-1:0]      sh;
    logic [DW-1:0]      next_sh;
    logic [CW-1:0]      cnt;
    logic [CW-1:0]      target;
    logic               uprev;
    logic               eop_line;
    logic               eop_d;
    logic               eop_ev;
    logic               bit_ok;
    logic               bit_v;
    logic               match;
    logic               done;
    logic [DW-1:0]      tbuf;
    logic [CW-1:0]      tcnt;
    logic               tfull;
    logic [DW-1:0]      tsh;
    logic [CW-1:0]      tleft;
    logic               tact;
    logic [7:0]         eopc;
    logic [2:0]         tones;
    logic               te;
    logic               tline;
    logic               thalf;
    logic [3:0]         tdiv;
    logic               tx_tick;
    logic               tbit;
    logic               stuff;
    logic               shift_on;
    logic               move;
    logic               underrun;
    logic               emit;
    logic               ebit;
    logic               ton;
    logic [PD-1:0]      dp;
    logic [PD-1:0]      dm;

    assign mode = CFG_I.protocol_sel;

    // Pins: s1 only feeds s2
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            s1 <= 4'h0;
            s2 <= 4'h0;
            clk_d <= 1'b0;
        end else begin
            s1 <= {SERIAL_CLK_PIN_I, RX_PLUS_I, RX_MINUS_I, RX_SERIAL_IN_I};
            s2 <= s1;
            clk_d <= s2[3];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I || div == 16'(INT_DIV - 1)) begin
            div <= 16'h0;
        end else begin
            div <= div + 16'h1;
        end
    end

    assign src_tick = CFG_I.ext_clk ? (s2[3] & ~clk_d) : (div == 16'(INT_DIV - 1));

    // 10Base-T data from the pair receiver, else the single input
    assign inv_bit  = (mode == mpsu_pkg::PRS_10BT ? s2[2] : s2[0]) ^ CFG_I.rx_invert;
    assign eop_line = ~s2[2] & ~s2[1];
    assign eop_ev   = eop_line & ~eop_d & (rx_state == mpsu_pkg::RX_DATA)
                      & (f_diff(mode) | mode == mpsu_pkg::PRS_GENERAL_SERIAL_MODE);
    assign next_sh  = {bit_v, sh[DW-1:1]};

    always_comb begin
        bit_ok = 1'b0;
        bit_v  = inv_bit;
        if (mode == mpsu_pkg::PRS_UART) begin
            bit_ok = src_tick && rx_state == mpsu_pkg::RX_DATA && rx_div == mpsu_pkg::OVS_LAST;
        end else if (src_tick) begin
            if (mode == mpsu_pkg::PRS_USB) begin
                bit_v  = (inv_bit == nrzi_prev);
                bit_ok = (ones != mpsu_pkg::STUFF_RUN);
            end else if (mode == mpsu_pkg::PRS_10BT) begin
                // Half-bit phase is free running; no clock recovery
                bit_ok = man_half;
            end else begin
                bit_ok = mode == mpsu_pkg::PRS_SPI || mode == mpsu_pkg::PRS_GENERAL_SERIAL_MODE;
            end
        end
    end

    assign match = rx_state == mpsu_pkg::RX_HUNT && bit_ok && f_diff(mode)
                   && {hist[6:0], bit_v} == SYNC_PATTERN_REG_I;
    assign done  = rx_state == mpsu_pkg::RX_DATA && bit_ok && !eop_ev
                   && CW'(cnt + 1'b1) == target;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rx_state <= mpsu_pkg::RX_HUNT;
        end else begin
            unique case (rx_state)
                mpsu_pkg::RX_HUNT: begin
                    if (match || mode == mpsu_pkg::PRS_SPI || mode == mpsu_pkg::PRS_GENERAL_SERIAL_MODE) begin
                        rx_state <= mpsu_pkg::RX_DATA;
                    end else if (mode == mpsu_pkg::PRS_UART && src_tick && uprev && !inv_bit) begin
                        rx_state <= mpsu_pkg::RX_START;
                    end
                end
                mpsu_pkg::RX_START: begin
                    if (mode != mpsu_pkg::PRS_UART) begin
                        rx_state <= mpsu_pkg::RX_HUNT;
                    end else if (src_tick && rx_div == mpsu_pkg::WAIT_LAST) begin
                        rx_state <= mpsu_pkg::RX_DATA;
                    end
                end
                mpsu_pkg::RX_DATA: begin
                    // Matching stays off here until end-of-packet
                    if (mode == mpsu_pkg::PRS_OFF || eop_ev || (done && mode == mpsu_pkg::PRS_UART)) begin
                        rx_state <= mpsu_pkg::RX_HUNT;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I || rx_state == mpsu_pkg::RX_HUNT) begin
            rx_div <= 4'h0;
        end else if (src_tick) begin
            rx_div <= (rx_state == mpsu_pkg::RX_START && rx_div == mpsu_pkg::WAIT_LAST)
                      ? 4'h0 : rx_div + 4'h1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I || rx_state != mpsu_pkg::RX_DATA) begin
            cnt <= '0;
            target <= RX_BIT_COUNT_REG_I;
        end else if (done) begin
            cnt <= '0;
            target <= RX_BIT_COUNT_REG_I;
        end else if (bit_ok && !eop_ev) begin
            cnt <= CW'(cnt + 1'b1);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            uprev <= 1'b1;
            nrzi_prev <= 1'b1;
            man_half <= 1'b0;
            ones <= 3'h0;
            hist <= 8'h0;
            sh <= '0;
            eop_d <= 1'b0;
        end else begin
            eop_d <= eop_line;
            if (src_tick) begin
                uprev <= inv_bit;
                nrzi_prev <= inv_bit;
                man_half <= (mode == mpsu_pkg::PRS_10BT) ? ~man_half : 1'b0;
                ones <= (mode != mpsu_pkg::PRS_USB || ones == mpsu_pkg::STUFF_RUN || !bit_v)
                        ? 3'h0 : ones + 3'h1;
            end
            if (bit_ok) begin
                hist <= {hist[6:0], bit_v};
                if (rx_state == mpsu_pkg::RX_DATA) begin
                    sh <= next_sh;
                end
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            RX_BUFFER_REG_O <= '0;
            RX_COUNT_O <= '0;
            RX_LOAD_O <= 1'b0;
        end else begin
            RX_LOAD_O <= eop_ev | done;
            if (eop_ev) begin
                RX_BUFFER_REG_O <= sh;
                RX_COUNT_O <= cnt;
            end else if (done) begin
                RX_BUFFER_REG_O <= next_sh;
                RX_COUNT_O <= target;
            end
        end
    end

    // Set beats a same-cycle clear
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            RX_EOP_O <= 1'b0;
        end else if (eop_ev) begin
            RX_EOP_O <= 1'b1;
        end else if (RX_EOP_CLR_I) begin
            RX_EOP_O <= 1'b0;
        end
    end

    // Transmit divider runs free, so its phase differs from receive
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            tdiv <= 4'h0;
        end else if (src_tick) begin
            tdiv <= tdiv + 4'h1;
        end
    end

    assign tx_tick  = (mode == mpsu_pkg::PRS_UART) ? src_tick && tdiv == mpsu_pkg::OVS_LAST : src_tick;
    assign tbit     = tx_tick && (mode != mpsu_pkg::PRS_10BT || thalf);
    assign stuff    = tact && mode == mpsu_pkg::PRS_USB && tones == mpsu_pkg::STUFF_RUN;
    assign shift_on = tleft != '0;
    assign move     = tbit && !stuff && !shift_on && tfull;
    assign underrun = tbit && !stuff && !shift_on && !tfull && tact;
    assign emit     = tbit && (stuff || shift_on || tfull);
    assign ebit     = stuff ? 1'b0 : (shift_on ? tsh[0] : tbuf[0]) ^ CFG_I.tx_invert;
    assign ton      = tact || eopc != 8'h0;
    assign TX_READY_O = ~tfull;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            tfull <= 1'b0;
            tbuf <= '0;
            tcnt <= '0;
        end else if (move) begin
            tfull <= 1'b0;
        end else if (TX_LOAD_I && !tfull) begin
            tfull <= 1'b1;
            tbuf <= TX_BUFFER_REG_I;
            tcnt <= TX_COUNT_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            tsh <= '0;
            tleft <= '0;
        end else if (emit && !stuff) begin
            if (shift_on) begin
                tsh <= tsh >> 1;
                tleft <= CW'(tleft - 1'b1);
            end else begin
                tsh <= tbuf >> 1;
                tleft <= CW'(tcnt - 1'b1);
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            tact <= 1'b0;
            eopc <= 8'h0;
        end else begin
            if (move) begin
                tact <= 1'b1;
            end else if (underrun || mode == mpsu_pkg::PRS_OFF) begin
                tact <= 1'b0;
            end
            if (underrun && f_diff(mode)) begin
                eopc <= 8'(EOP_SLOTS);
            end else if (tbit && eopc != 8'h0) begin
                eopc <= eopc - 8'h1;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            tones <= 3'h0;
            te <= 1'b0;
            tline <= 1'b1;
            thalf <= 1'b0;
        end else begin
            if (tx_tick) begin
                thalf <= (mode == mpsu_pkg::PRS_10BT) ? ~thalf : 1'b0;
            end
            if (emit) begin
                te <= ebit;
                tones <= ebit ? tones + 3'h1 : 3'h0;
            end
            if (emit && mode == mpsu_pkg::PRS_USB && !ebit) begin
                tline <= ~tline;
            end else if (!ton) begin
                tline <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            TX_PLUS_O <= 1'b0;
            TX_MINUS_O <= 1'b0;
            XCVR_OUT_EN_N_O <= 1'b1;
        end else begin
            XCVR_OUT_EN_N_O <= !(mode == mpsu_pkg::PRS_USB && ton);
            if (mode == mpsu_pkg::PRS_USB) begin
                TX_PLUS_O <= (eopc == 8'h0) & tline;
                TX_MINUS_O <= (eopc == 8'h0) & ~tline;
            end else if (mode == mpsu_pkg::PRS_10BT) begin
                // First half carries the complement
                TX_PLUS_O <= tact ? (thalf ? te : ~te) : (eopc != 8'h0);
                TX_MINUS_O <= tact & (thalf ? ~te : te);
            end else begin
                TX_PLUS_O <= f_plain(mode) & (tact ? te : 1'b1);
                TX_MINUS_O <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            dp <= '0;
            dm <= '0;
            TX_PLUS_PREEMPH_O <= 1'b0;
            TX_MINUS_PREEMPH_O <= 1'b0;
        end else begin
            dp <= {dp[PD-2:0], TX_PLUS_O};
            dm <= {dm[PD-2:0], TX_MINUS_O};
            TX_PLUS_PREEMPH_O <= (mode == mpsu_pkg::PRS_10BT) & dp[PD-1];
            TX_MINUS_PREEMPH_O <= (mode == mpsu_pkg::PRS_10BT) & dm[PD-1];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= ((eop_ev | done) & CFG_I.rx_full_irq_en)
                     | (move & CFG_I.tx_empty_irq_en)
                     | (underrun & CFG_I.tx_underrun_irq_en);
        end
    end

    a_oe_usb_only: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        mode != mpsu_pkg::PRS_USB |=> XCVR_OUT_EN_N_O)
        else $error("transceiver enable low outside usb");
    a_idle_low_10bt: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (mode == mpsu_pkg::PRS_10BT && !ton) |=> !TX_PLUS_O && !TX_MINUS_O)
        else $error("10base-t outputs not low when idle");
    a_preemph_delay: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        $past(mode == mpsu_pkg::PRS_10BT)
        |-> TX_PLUS_PREEMPH_O == $past(TX_PLUS_O, mpsu_pkg::PREEMPH_CYC))
        else $error("pre-emphasis not a 13 cycle copy");
    a_rx_irq_gate: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (RX_LOAD_O && $past(CFG_I.rx_full_irq_en)) |-> IRQ_O)
        else $error("receive load interrupt missing");
    a_tx_load_take: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (TX_LOAD_I && TX_READY_O) |=> !TX_READY_O)
        else $error("transmit buffer not taken");
    a_sync_hold: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (rx_state == mpsu_pkg::RX_DATA && !eop_ev && f_diff(mode)) |=> rx_state == mpsu_pkg::RX_DATA)
        else $error("framing dropped before end-of-packet");
    a_sync_start: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        match |=> rx_state == mpsu_pkg::RX_DATA && cnt == '0)
        else $error("sync match did not start reception");
    a_uart_wait: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (rx_state == mpsu_pkg::RX_START && mode == mpsu_pkg::PRS_UART
         && rx_div < mpsu_pkg::WAIT_LAST)
        |=> rx_state == mpsu_pkg::RX_START)
        else $error("uart start wait cut short");
    a_eop_capture: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        eop_ev |=> RX_EOP_O && RX_LOAD_O && RX_COUNT_O == $past(cnt))
        else $error("end-of-packet capture wrong");
    a_underrun_irq: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (underrun && CFG_I.tx_underrun_irq_en) |=> IRQ_O)
        else $error("underrun interrupt missing");
endmodule : mpsu_top
`default_nettype wire

/* tb/mpsu_line_peer.sv */
`default_nettype none
module mpsu_line_peer #(
    parameter int BIT_CYC = 32
) (
    input  wire logic clk_i,
    output logic      pin_clk_o,
    output logic      ser_o,
    output logic      plus_o,
    output logic      minus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lvl = 1'b1;
    initial begin
        pin_clk_o = 1'b0;
        ser_o     = 1'b1;
        plus_o    = 1'b1;
        minus_o   = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    // Data settles before the edge so both synchronisers agree
    task automatic tick();
        cyc(3);
        pin_clk_o <= 1'b1;
        cyc(3);
        pin_clk_o <= 1'b0;
    endtask : tick
    // A zero is a line change
    task automatic usb_bit(input logic b);
        @(posedge clk_i);
        lvl = b ? lvl : ~lvl;
        ser_o <= lvl;
        tick();
    endtask : usb_bit
    task automatic plain_bit(input logic b);
        @(posedge clk_i);
        ser_o <= b;
        tick();
    endtask : plain_bit
    task automatic eop();
        @(posedge clk_i);
        plus_o <= 1'b0;
        cyc(8);
        plus_o <= 1'b1;
    endtask : eop
    task automatic uart_byte(input logic [7:0] d);
        @(posedge clk_i);
        ser_o <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            cyc(BIT_CYC);
            ser_o <= (i < 8) ? d[i] : 1'b1;
        end
        cyc(BIT_CYC);
    endtask : uart_byte
endmodule : mpsu_line_peer
`default_nettype wire

/* tb/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clk = 1'b0, rst = 1'b1, eclr = 1'b0, tload = 1'b0, pe_on = 1'b0;
    mpsu_pkg::mpsu_cfg_s cfg = '0;
    logic [7:0]          sync = 8'h55, tbuf = 8'h00, rbuf;
    logic [3:0]          rcnt = 4'h8, tcnt = 4'h6;
    logic [3:0]          rcount;
    logic                rload, reop, trdy, irq, pclk, rxd, rxp, rxm, se0 = 1'b0;
    logic                txp, txm, txpe, txme, oen_n;
    logic [12:0]         hp = '0, hm = '0;
    int                  errors = 0, n_tests = 0, irqs = 0, loads = 0, cycles = 0, i0, l0;

    mpsu_top #(.DW(8), .CW(4), .INT_DIV(2), .EOP_SLOTS(2)) dut (
        .CLK_I(clk), .RST_I(rst), .CFG_I(cfg), .SYNC_PATTERN_REG_I(sync),
        .RX_BIT_COUNT_REG_I(rcnt), .RX_BUFFER_REG_O(rbuf), .RX_COUNT_O(rcount),
        .RX_LOAD_O(rload), .RX_EOP_O(reop), .RX_EOP_CLR_I(eclr), .TX_BUFFER_REG_I(tbuf),
        .TX_COUNT_I(tcnt), .TX_LOAD_I(tload), .TX_READY_O(trdy), .IRQ_O(irq),
        .SERIAL_CLK_PIN_I(pclk), .RX_SERIAL_IN_I(rxd), .RX_PLUS_I(rxp), .RX_MINUS_I(rxm),
        .TX_PLUS_O(txp), .TX_MINUS_O(txm), .TX_PLUS_PREEMPH_O(txpe),
        .TX_MINUS_PREEMPH_O(txme), .XCVR_OUT_EN_N_O(oen_n));
    mpsu_line_peer #(.BIT_CYC(32)) peer (
        .clk_i(clk), .pin_clk_o(pclk), .ser_o(rxd), .plus_o(rxp), .minus_o(rxm));

    always #2 clk = ~clk;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("Checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // Passing through off returns the receiver to hunt
    task automatic mode(input logic [3:0] p, input logic [1:0] inv, input logic ext,
                        input logic [2:0] en);
        @(posedge clk);
        cfg <= '0;
        @(posedge clk);
        cfg <= {p, inv, ext, en};
        i0 = irqs;
        l0 = loads;
    endtask : mode
    task automatic send(input logic [7:0] d);
        @(posedge clk);
        tbuf  <= d;
        tload <= 1'b1;
        @(posedge clk);
        tload <= 1'b0;
        #1 check("ready_low", trdy, 1'b0);
    endtask : send

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (irq === 1'b1) irqs <= irqs + 1;
        if (rload === 1'b1) loads <= loads + 1;
        if (txp === 1'b0 && txm === 1'b0 && oen_n === 1'b0) se0 <= 1'b1;
        hp <= {hp[11:0], txp};
        hm <= {hm[11:0], txm};
        if (pe_on) check("preemph_p", txpe, hp[12]);
        if (pe_on) check("preemph_m", txme, hm[12]);
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end

    initial begin
        cyc(2);
        rst <= 1'b0;
        #1 check("ready_rst", trdy, 1'b1);
        check("oen_rst", oen_n, 1'b1);
        // Six inverted plain bits, one per pin clock, only the underrun event enabled
        mode(mpsu_pkg::PRS_GENERAL_SERIAL_MODE, 2'b01, 1'b1, 3'b001);
        send(8'hc5);
        for (int i = 0; i < 6; i++) begin
            peer.tick();
            cyc(4);
            #1 check("general_serial_mode_bit", txp, 8'(~(8'hc5 >> i)) & 8'h01);
        end
        repeat (2) peer.tick();
        tcnt <= 4'h8;
        cyc(4);
        #1 check("general_serial_mode_irq", 8'(irqs - i0), 8'h01);
        check("general_serial_mode_idle", txp, 1'b1);
        check("general_serial_mode_oen", oen_n, 1'b1);
        mode(mpsu_pkg::PRS_USB, 2'b00, 1'b0, 3'b011);
        se0 <= 1'b0;
        send(8'h3c);
        for (int i = 0; i < 200 && oen_n !== 1'b0; i++) @(posedge clk);
        #1 check("usb_oen_on", oen_n, 1'b0);
        for (int i = 0; i < 400 && oen_n !== 1'b1; i++) @(posedge clk);
        cyc(2);
        #1 check("usb_oen_off", oen_n, 1'b1);
        check("usb_se0", se0, 1'b1);
        check("usb_idle", {txp, txm}, 2'b10);
        check("usb_irq", 8'(irqs - i0), 8'h02);
        mode(mpsu_pkg::PRS_10BT, 2'b00, 1'b0, 3'b010);
        cyc(20);
        pe_on <= 1'b1;
        send(8'h96);
        cyc(300);
        pe_on <= 1'b0;
        #1 check("bt_idle", {txp, txm}, 2'b00);
        check("bt_irq", 8'(irqs - i0), 8'h01);
        // Start bit, eight data bits, no interrupt allowed
        mode(mpsu_pkg::PRS_UART, 2'b00, 1'b0, 3'b000);
        peer.uart_byte(8'h4b);
        #1 check("uart_data", rbuf, 8'h4b);
        check("uart_cnt", rcount, 4'h8);
        check("uart_loads", 8'(loads - l0), 8'h01);
        check("uart_irq", 8'(irqs - i0), 8'h00);
        check("uart_pe", txpe, 1'b0);
        mode(mpsu_pkg::PRS_USB, 2'b00, 1'b1, 3'b100);
        for (int i = 0; i < 8; i++) peer.usb_bit(1'b1);
        sync <= mpsu_pkg::SYNC_USB;
        for (int i = 15; i >= 0; i--) peer.usb_bit(1'(16'h017e >> i));
        peer.eop();
        for (int i = 0; i < 50 && reop !== 1'b1; i++) @(posedge clk);
        cyc(2);
        #1 check("usb_eop", reop, 1'b1);
        check("usb_cnt", rcount, 4'h7);
        check("usb_data", rbuf[7:1], 7'h7e);
        check("usb_loads", 8'(loads - l0), 8'h01);
        check("usb_rirq", 8'(irqs - i0), 8'h01);
        cyc(1);
        eclr <= 1'b1;
        cyc(1);
        eclr <= 1'b0;
        rcnt <= 4'h4;
        cyc(1);
        #1 check("eop_clr", reop, 1'b0);
        // Four-bit words on the single input, received inverted
        mode(mpsu_pkg::PRS_SPI, 2'b10, 1'b1, 3'b100);
        for (int i = 0; i < 4; i++) peer.plain_bit(1'(4'hd >> i));
        cyc(2);
        #1 check("spi_data", rbuf[7:4], 4'h2);
        check("spi_cnt", rcount, 4'h4);
        check("spi_loads", 8'(loads - l0), 8'h01);
        check("spi_irq", 8'(irqs - i0), 8'h01);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
